// ---- mrp_pkg.sv ----
package mrp_pkg;

    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          CORE_CLOCK_PER_PCLK  = 2;
    localparam int          PCLK_PERIOD_NS = CLK_PERIOD_NS * CORE_CLOCK_PER_PCLK;
    localparam int          BUS_W          = 16;
    localparam int          BYTE_W         = 8;
    localparam int          ADDR_W         = 24;
    localparam int          DUR_W          = 5;
    localparam int          TMR_W          = DUR_W + 2;
    localparam int          BURST8         = 4;
    localparam logic [4:0]  ALE_PCLKS      = 5'h01;
    localparam logic [4:0]  ADDR_HOLD_PCLK = 5'h01;
    localparam logic [4:0]  TURN_PCLKS     = 5'h01;
    localparam logic [4:0]  HOLD_PCLKS     = 5'h01;
    localparam logic [4:0]  RECOV_PCLKS    = 5'h01;
    localparam logic [4:0]  SLOW_PCLKS     = 5'h07;
    localparam logic [4:0]  MIN_DUR        = 5'h01;
    localparam logic        ALE_POL_RESET  = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ALE_LEAD,
        ST_ALE_ADDR,
        ST_ADDR_HOLD,
        ST_TURN,
        ST_STROBE,
        ST_HOLD,
        ST_RECOV,
        ST_SLOW
    } mrp_state_type;

endpackage

// ---- mrp_tmr_if.sv ----
interface mrp_tmr_if;
    import mrp_pkg::*;

    logic             start;
    logic [DUR_W-1:0] periods;
    logic             done;

    modport ctl (output start, output periods, input done);
    modport tmr (input start, input periods, output done);
endinterface

// ---- mrp_pclk_timer.sv ----
module mrp_pclk_timer
    import mrp_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    mrp_tmr_if.tmr    tmr
);

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    logic             busy_q;
    logic             busy_d;

    // Every duration is a whole number of peripheral clocks, each two core clocks long.
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        if (tmr.start) begin
            cnt_d  = TMR_W'(int'(tmr.periods) * CORE_CLOCK_PER_PCLK - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q - TMR_W'(1);
            end
        end
    end

    assign tmr.done = busy_q && (cnt_q == '0);

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

endmodule // mrp_pclk_timer

// ---- mrp_read_port.sv ----
module mrp_read_port
    import mrp_pkg::*;
#(
    parameter int CNT_W  = 4,
    parameter int STEP_W = 16
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rstn_in,
    input  wire logic [DUR_W-1:0]    data_cycle_duration_in,
    input  wire logic                hold_cycle_en_in,
    input  wire logic                slow_device_en_in,
    input  wire logic                width16_in,
    input  wire logic [STEP_W-1:0]   external_modify_step_in,
    input  wire logic                ale_pol_wr_in,
    input  wire logic                ale_active_low_in,
    input  wire logic                rd_req_in,
    input  wire logic [ADDR_W-1:0]   rd_addr_in,
    input  wire logic [CNT_W-1:0]    rd_count_in,
    output logic                     rd_ready_out,
    output logic [BUS_W-1:0]         rd_data_out,
    output logic                     rd_data_valid_out,
    output logic                     ale_out,
    output logic                     rd_n_out,
    input  wire logic [BUS_W-1:0]    muxed_bus_in,
    output logic [BUS_W-1:0]         muxed_bus_out,
    output logic                     muxed_bus_low_byte_oe_out,
    output logic                     muxed_bus_high_byte_oe_out,
    output logic                     busy_out
);

    mrp_tmr_if tmr_if ();

    mrp_pclk_timer u_timer (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .tmr        (tmr_if.tmr)
    );

    mrp_state_type     state_q;
    mrp_state_type     state_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [CNT_W-1:0]  left_q;
    logic [CNT_W-1:0]  left_d;
    logic [BYTE_W-1:0] beat_q;
    logic [BYTE_W-1:0] beat_d;
    logic [DUR_W-1:0]  dur_q;
    logic [DUR_W-1:0]  dur_d;
    logic              hold_q;
    logic              hold_d;
    logic              slow_q;
    logic              slow_d;
    logic              w16_q;
    logic              w16_d;
    logic              ale_low_q;
    logic              ale_low_d;
    logic [BUS_W-1:0]  data_q;
    logic [BUS_W-1:0]  data_d;
    logic              valid_q;
    logic              valid_d;
    logic              more;
    logic [CNT_W-1:0]  beats;

    logic [BUS_W-1:0]  sync1_q;
    logic [BUS_W-1:0]  sync2_q;
    logic [BUS_W-1:0]  sync3_q;
    logic [BUS_W-1:0]  stable_q;
    logic [BUS_W-1:0]  stable_d;

    logic              ale_act_q;
    logic              ale_act_d;
    logic              rd_n_q;
    logic              rd_n_d;
    logic [BUS_W-1:0]  bus_q;
    logic [BUS_W-1:0]  bus_d;
    logic              oe_lo_q;
    logic              oe_lo_d;
    logic              oe_hi_q;
    logic              oe_hi_d;

    // Pin data is only trusted once the second and third stages agree.
    always_comb begin
        stable_d = (sync2_q == sync3_q) ? sync3_q : stable_q;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q  <= '0;
            sync2_q  <= '0;
            sync3_q  <= '0;
            stable_q <= '0;
        end else begin
            sync1_q  <= muxed_bus_in;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            stable_q <= stable_d;
        end
    end

    always_comb begin
        if (!width16_in) begin
            beats = CNT_W'(BURST8);
        end else if (external_modify_step_in != '0 || rd_count_in == '0) begin
            beats = CNT_W'(1);
        end else begin
            beats = rd_count_in;
        end
    end

    always_comb begin
        state_d        = state_q;
        addr_d         = addr_q;
        left_d         = left_q;
        beat_d         = beat_q;
        dur_d          = dur_q;
        hold_d         = hold_q;
        slow_d         = slow_q;
        w16_d          = w16_q;
        ale_low_d      = ale_low_q;
        data_d         = data_q;
        valid_d        = 1'b0;
        tmr_if.start   = 1'b0;
        tmr_if.periods = MIN_DUR;
        more           = (state_q == ST_STROBE) ? (left_q > CNT_W'(1)) : (left_q != '0);
        if (ale_pol_wr_in) begin
            ale_low_d = ale_active_low_in;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (rd_req_in) begin
                    addr_d         = rd_addr_in;
                    left_d         = beats;
                    beat_d         = '0;
                    dur_d          = (data_cycle_duration_in == '0) ? MIN_DUR : data_cycle_duration_in;
                    hold_d         = hold_cycle_en_in;
                    slow_d         = slow_device_en_in;
                    w16_d          = width16_in;
                    state_d        = ST_ALE_LEAD;
                    tmr_if.start   = 1'b1;
                    tmr_if.periods = ALE_PCLKS;
                end
            end
            ST_ALE_LEAD: begin
                if (tmr_if.done) begin
                    state_d        = ST_ALE_ADDR;
                    tmr_if.start   = 1'b1;
                    tmr_if.periods = ALE_PCLKS;
                end
            end
            ST_ALE_ADDR: begin
                if (tmr_if.done) begin
                    state_d        = ST_ADDR_HOLD;
                    tmr_if.start   = 1'b1;
                    tmr_if.periods = ADDR_HOLD_PCLK;
                end
            end
            ST_ADDR_HOLD: begin
                if (tmr_if.done) begin
                    state_d        = ST_TURN;
                    tmr_if.start   = 1'b1;
                    tmr_if.periods = TURN_PCLKS;
                end
            end
            ST_TURN, ST_RECOV: begin
                if (tmr_if.done) begin
                    state_d        = ST_STROBE;
                    tmr_if.start   = 1'b1;
                    tmr_if.periods = dur_q;
                end
            end
            ST_STROBE, ST_HOLD: begin
                if (tmr_if.done) begin
                    if (state_q == ST_STROBE) begin
                        left_d  = left_q - CNT_W'(1);
                        valid_d = 1'b1;
                        // Sampled on the same edge that raises the strobe.
                        data_d  = w16_q ? stable_q : {{(BUS_W-BYTE_W){1'b0}}, stable_q[BYTE_W-1:0]};
                    end
                    tmr_if.start = 1'b1;
                    if (state_q == ST_STROBE && hold_q) begin
                        state_d        = ST_HOLD;
                        tmr_if.periods = HOLD_PCLKS;
                    end else if (more) begin
                        state_d        = ST_RECOV;
                        beat_d         = beat_q + BYTE_W'(1);
                        tmr_if.periods = RECOV_PCLKS;
                    end else if (slow_q) begin
                        state_d        = ST_SLOW;
                        tmr_if.periods = SLOW_PCLKS;
                    end else begin
                        state_d      = ST_IDLE;
                        tmr_if.start = 1'b0;
                    end
                end
            end
            ST_SLOW: begin
                if (tmr_if.done) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q   <= ST_IDLE;
            addr_q    <= '0;
            left_q    <= '0;
            beat_q    <= '0;
            dur_q     <= MIN_DUR;
            hold_q    <= 1'b0;
            slow_q    <= 1'b0;
            w16_q     <= 1'b0;
            ale_low_q <= ALE_POL_RESET;
            data_q    <= '0;
            valid_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            addr_q    <= addr_d;
            left_q    <= left_d;
            beat_q    <= beat_d;
            dur_q     <= dur_d;
            hold_q    <= hold_d;
            slow_q    <= slow_d;
            w16_q     <= w16_d;
            ale_low_q <= ale_low_d;
            data_q    <= data_d;
            valid_q   <= valid_d;
        end
    end

    // Pins are decoded from the next state and registered, so strobes never glitch.
    // In 8-bit width the latch carries the upper sixteen address bits and the
    // high byte lines carry the low byte, stepping once per strobe.
    always_comb begin
        ale_act_d = (state_d == ST_ALE_LEAD) || (state_d == ST_ALE_ADDR);
        rd_n_d    = (state_d != ST_STROBE);
        bus_d     = '0;
        oe_lo_d   = 1'b0;
        oe_hi_d   = 1'b0;
        unique case (state_d)
            ST_ALE_ADDR, ST_ADDR_HOLD: begin
                bus_d   = w16_d ? addr_d[BUS_W-1:0] : addr_d[ADDR_W-1:ADDR_W-BUS_W];
                oe_lo_d = 1'b1;
                oe_hi_d = 1'b1;
            end
            ST_TURN, ST_STROBE, ST_HOLD, ST_RECOV: begin
                oe_hi_d = !w16_d;
                if (!w16_d) begin
                    bus_d[BUS_W-1:BYTE_W] = addr_d[BYTE_W-1:0] + beat_d;
                end
            end
            default: begin
                oe_lo_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ale_act_q <= 1'b0;
            rd_n_q    <= 1'b1;
            bus_q     <= '0;
            oe_lo_q   <= 1'b0;
            oe_hi_q   <= 1'b0;
        end else begin
            ale_act_q <= ale_act_d;
            rd_n_q    <= rd_n_d;
            bus_q     <= bus_d;
            oe_lo_q   <= oe_lo_d;
            oe_hi_q   <= oe_hi_d;
        end
    end

    assign ale_out                    = ale_act_q ^ ale_low_q;
    assign rd_n_out                   = rd_n_q;
    assign muxed_bus_out              = bus_q;
    assign muxed_bus_low_byte_oe_out  = oe_lo_q;
    assign muxed_bus_high_byte_oe_out = oe_hi_q;
    assign rd_data_out                = data_q;
    assign rd_data_valid_out          = valid_q;
    assign rd_ready_out               = (state_q == ST_IDLE);
    assign busy_out                   = (state_q != ST_IDLE);

    // Helper counters watched only by the checks below.
    logic [TMR_W-1:0] low_cnt_q;
    logic [TMR_W-1:0] since_rd_q;
    logic [CNT_W:0]   strobes_q;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt_q  <= '0;
            since_rd_q <= '0;
            strobes_q  <= '0;
        end else begin
            low_cnt_q  <= rd_n_q ? '0 : low_cnt_q + TMR_W'(1);
            since_rd_q <= !rd_n_q ? '0 : (&since_rd_q ? since_rd_q : since_rd_q + TMR_W'(1));
            if (ale_act_q && !ale_act_d) begin
                strobes_q <= '0;
            end else if (!rd_n_d && rd_n_q) begin
                strobes_q <= strobes_q + (CNT_W+1)'(1);
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    sequence ale_end_seq;
        $fell(ale_act_q);
    endsequence

    sequence turn_seq;
        rd_n_q[*4] ##1 !rd_n_q;
    endsequence

    a_ale_width: assert property ($rose(ale_act_q) |-> ale_act_q[*4] ##1 !ale_act_q)
        else $error("address latch strobe width wrong");
    a_addr_overlap: assert property ($fell(ale_act_q) |-> $past(oe_lo_q) && oe_lo_q[*2] ##1 !oe_lo_q)
        else $error("address not held one clock after latch then released");
    a_first_read: assert property (ale_end_seq |-> turn_seq)
        else $error("first read strobe not two clocks after latch");
    a_read_width: assert property ($rose(rd_n_q) |-> low_cnt_q == TMR_W'(int'(dur_q) * CORE_CLOCK_PER_PCLK))
        else $error("read strobe low time differs from data cycle duration");
    a_read_recovery: assert property ($rose(rd_n_q) |-> rd_n_q[*2] ##1 (rd_n_q || !hold_q))
        else $error("read strobes too close together");
    a_latch_after_read: assert property ($rose(ale_act_q) && strobes_q != '0
        |-> since_rd_q >= TMR_W'(($past(hold_q) ? 2 : 0) + ($past(slow_q) ? 14 : 0)))
        else $error("latch strobe too soon after last read");
    a_slow_quiet: assert property ($rose(rd_n_q) && slow_q && left_q == '0 && !hold_q
        |-> (!ale_act_q && !oe_lo_q)[*8])
        else $error("slow mode recovery cut short");
    a_capture_edge: assert property ($rose(rd_n_q) |-> valid_q)
        else $error("read data not captured at strobe rise");
    a_burst_four: assert property ($rose(ale_act_q) && strobes_q != '0 && !$past(w16_q)
        |-> strobes_q == (CNT_W+1)'(BURST8))
        else $error("8-bit burst is not four strobes");
    a_high_byte: assert property (!rd_n_q && !w16_q |-> oe_hi_q ##1 (oe_hi_q || !hold_q))
        else $error("upper address byte missing during read");

endmodule // mrp_read_port

// ---- mrp_mem_model.sv ----
module mrp_mem_model
    import mrp_pkg::*;
(
    input  wire logic             clk_sys_in,
    input  wire logic             ale_in,
    input  wire logic             ale_active_low_in,
    input  wire logic             rd_n_in,
    input  wire logic             width16_in,
    input  wire logic [3:0]       delay_in,
    input  wire logic [BUS_W-1:0] drive_in,
    input  wire logic             oe_low_in,
    input  wire logic             oe_high_in,
    output logic [BUS_W-1:0]      muxed_bus_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic              act_q   = 1'b0;
    logic [BUS_W-1:0]  lat_q   = 16'h0000;
    logic [BUS_W-1:0]  noise_q = 16'hA5A5;
    int                low_cnt = 0;
    logic [ADDR_W-1:0] addr_full;
    logic [BUS_W-1:0]  word;
    logic              drv;

    // Undriven lines show a pattern that changes every cycle, so a stale capture cannot pass.
    always @(posedge clk_sys_in) begin
        act_q   <= ale_in ^ ale_active_low_in;
        if (act_q && !(ale_in ^ ale_active_low_in)) begin
            lat_q <= muxed_bus_out;
        end
        noise_q <= ~noise_q ^ 16'h0101;
        low_cnt <= rd_n_in ? 0 : low_cnt + 1;
    end

    always_comb begin
        addr_full = width16_in ? {8'h00, lat_q} : {lat_q, drive_in[15:8]};
        word      = {addr_full[15:8] ^ addr_full[23:16] ^ 8'h5A, addr_full[7:0] ^ 8'hC3};
        // Data only appears after delay_in cycles of the strobe and vanishes at its rise.
        drv       = !rd_n_in && (low_cnt >= int'(delay_in));
        muxed_bus_out[7:0]  = oe_low_in ? drive_in[7:0] : (drv ? word[7:0] : noise_q[7:0]);
        muxed_bus_out[15:8] = oe_high_in ? drive_in[15:8] :
                              ((drv && width16_in) ? word[15:8] : noise_q[15:8]);
    end
endmodule // mrp_mem_model

// ---- mrp_read_port_test.sv ----
module mrp_read_port_test;
    import mrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_sys_in;
    logic                rstn_in;
    logic [DUR_W-1:0]    dur;
    logic                hold;
    logic                slow;
    logic                w16;
    logic [15:0]         step;
    logic                pol_wr;
    logic                pol_low;
    logic                req;
    logic [ADDR_W-1:0]   addr;
    logic [3:0]          cnt;
    logic [3:0]          dly;
    logic                rd_ready_out;
    logic [BUS_W-1:0]    rd_data_out;
    logic                rd_data_valid_out;
    logic                ale_out;
    logic                rd_n_out;
    logic [BUS_W-1:0]    bus_wire;
    logic [BUS_W-1:0]    bus_drive;
    logic                oe_lo;
    logic                oe_hi;
    logic                busy_out;
    int                  n_fail;
    int                  cmp_count;
    int                  cyc, ale_n, strb, ale_rise, ale_fall, ale_len, ale_gap;
    int                  rd_fall, rd_rise, rd_len, r2f, fall_gap, g0, g1;
    logic                act, act_p, rd_p, first, bad_oe, bad_hi;
    logic [15:0]         got[$];

    mrp_read_port DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .data_cycle_duration_in(dur),
        .hold_cycle_en_in(hold), .slow_device_en_in(slow), .width16_in(w16), .external_modify_step_in(step),
        .ale_pol_wr_in(pol_wr), .ale_active_low_in(pol_low), .rd_req_in(req), .rd_addr_in(addr),
        .rd_count_in(cnt), .rd_ready_out(rd_ready_out), .rd_data_out(rd_data_out),
        .rd_data_valid_out(rd_data_valid_out), .ale_out(ale_out), .rd_n_out(rd_n_out),
        .muxed_bus_in(bus_wire), .muxed_bus_out(bus_drive), .muxed_bus_low_byte_oe_out(oe_lo),
        .muxed_bus_high_byte_oe_out(oe_hi), .busy_out(busy_out));

    mrp_mem_model mem (.clk_sys_in(clk_sys_in), .ale_in(ale_out), .ale_active_low_in(pol_low),
        .rd_n_in(rd_n_out), .width16_in(w16), .delay_in(dly), .drive_in(bus_drive), .oe_low_in(oe_lo),
        .oe_high_in(oe_hi), .muxed_bus_out(bus_wire));

    initial begin
        clk_sys_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [15:0] mem_word(input logic [23:0] a);
        return {a[15:8] ^ a[23:16] ^ 8'h5A, a[7:0] ^ 8'hC3};
    endfunction

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // One access: request held until taken, then wait for the port to go idle again.
    task automatic rd(input logic [23:0] a, input logic wide, input logic [15:0] st, input logic [3:0] n,
                      input logic [4:0] d, input logic h, input logic s);
        @(posedge clk_sys_in);
        addr <= a;
        w16 <= wide;
        step <= st;
        cnt <= n;
        dur <= d;
        hold <= h;
        slow <= s;
        req <= 1'b1;
        strb = 0;
        ale_n = 0;
        bad_oe = 1'b0;
        bad_hi = 1'b0;
        got.delete();
        // A port that never goes idle again is caught by the cycle limit below.
        do @(posedge clk_sys_in); while (rd_ready_out !== 1'b1);
        req <= 1'b0;
        do @(posedge clk_sys_in); while (rd_ready_out !== 1'b1);
        @(posedge clk_sys_in);
    endtask

    // Edge monitor; every figure is a difference of cycle stamps, so sampling offsets cancel.
    always @(posedge clk_sys_in) begin
        cyc++;
        act = ale_out ^ pol_low;
        if (rstn_in) begin
            if (act && !act_p) begin ale_n++; ale_rise = cyc; ale_gap = cyc - rd_rise; end
            if (!act && act_p) begin ale_len = cyc - ale_rise; ale_fall = cyc; first = 1'b1; end
            if (!rd_n_out && rd_p) begin
                strb++;
                if (first) fall_gap = cyc - ale_fall;
                else r2f = cyc - rd_rise;
                first = 1'b0;
                rd_fall = cyc;
                if (oe_lo !== 1'b0) bad_oe = 1'b1;
            end
            if (rd_n_out && !rd_p) begin
                rd_len = cyc - rd_fall;
                rd_rise = cyc;
            end
            if (!rd_n_out && !w16 && oe_hi !== 1'b1) bad_hi = 1'b1;
            if (rd_data_valid_out === 1'b1) got.push_back(rd_data_out);
        end
        act_p = act;
        rd_p = rd_n_out;
        if (cyc > 20000) begin
            n_fail++;
            $display("Error at %0t: cycle limit reached", $time);
            finish_test();
        end
    end

    initial begin
        n_fail = 0; cmp_count = 0; cyc = 0; act_p = 1'b0; rd_p = 1'b1; first = 1'b0; rd_rise = 0;
        rstn_in = 1'b0; dur = 5'h03; hold = 1'b0; slow = 1'b0; w16 = 1'b1; step = 16'h0001;
        pol_wr = 1'b0; pol_low = 1'b0; req = 1'b0; addr = 24'h000000; cnt = 4'h1; dly = 4'h0;
        repeat (12) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        chk(ale_out, 1'b0);
        chk({rd_n_out, oe_lo, oe_hi, rd_ready_out, busy_out}, 5'h12);
        rd(24'h123456, 1'b1, 16'h0001, 4'h3, 5'h03, 1'b0, 1'b0);
        chk(ale_n, 1);
        chk(strb, 1);
        chk(got.size(), 1);
        foreach (got[i]) chk(got[i], mem_word(24'h003456));
        chk(rd_len, 3 * CORE_CLOCK_PER_PCLK);
        chk(ale_len, 2 * CORE_CLOCK_PER_PCLK);
        chk(fall_gap, 2 * CORE_CLOCK_PER_PCLK);
        chk(bad_oe, 1'b0);
        rd(24'h00BEEF, 1'b1, 16'h0000, 4'h3, 5'h03, 1'b1, 1'b0);
        chk(ale_n, 1);
        chk(strb, 3);
        chk(r2f, 2 * CORE_CLOCK_PER_PCLK);
        foreach (got[i]) chk(got[i], mem_word(24'h00BEEF));
        dly <= 4'h3;
        rd(24'hA1B240, 1'b0, 16'h0001, 4'h1, 5'h04, 1'b0, 1'b0);
        chk(ale_n, 1);
        chk(strb, 4);
        chk(got.size(), 4);
        foreach (got[i]) chk(got[i], mem_word({16'hA1B2, 8'h40 + 8'(i)}) & 16'h00FF);
        chk(bad_hi, 1'b0);
        chk(r2f, CORE_CLOCK_PER_PCLK);
        chk(rd_len, 4 * CORE_CLOCK_PER_PCLK);
        dly <= 4'h0;
        rd(24'h001111, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b0);
        rd(24'h002222, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b0);
        g0 = ale_gap;
        rd(24'h003333, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b1);
        rd(24'h004444, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b0);
        g1 = ale_gap;
        chk(g1 - g0, 7 * CORE_CLOCK_PER_PCLK);
        rd(24'h005555, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b1, 1'b0);
        rd(24'h006666, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b0);
        chk(ale_gap - g0, CORE_CLOCK_PER_PCLK);
        foreach (got[i]) chk(got[i], mem_word(24'h006666));
        @(posedge clk_sys_in);
        pol_wr <= 1'b1;
        pol_low <= 1'b1;
        @(posedge clk_sys_in);
        pol_wr <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        chk(ale_out, 1'b1);
        rd(24'h00C0DE, 1'b1, 16'h0001, 4'h1, 5'h03, 1'b0, 1'b0);
        chk(ale_n, 1);
        chk(ale_len, 2 * CORE_CLOCK_PER_PCLK);
        foreach (got[i]) chk(got[i], mem_word(24'h00C0DE));
        finish_test();
    end
endmodule // mrp_read_port_test
